// >>> hw/rsc_params.svh
// constants of the system reset controller
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_SWRST 8'h01
`define RSC_BIT_DEBUG 5
`define RSC_BIT_SOFT 4
`define RSC_BIT_WDOG 3
`define RSC_BIT_PIN 2
`define RSC_BIT_BOD 1
`define RSC_BIT_POR 0
`define RSC_BIT_TRIGGER 0
`define RSC_SWRST_RESET 8'h00
`define RSC_CAUSE_MASK 8'h3F
`define RSC_INIT_BASE 16
`define RSC_SUT_STEP 64
`define RSC_SCAN_CYCLES 256
`define RSC_FUSE_LOAD 8
`define RSC_CCP_WINDOW 4
`define RSC_KEY_IO_REGISTER_UNLOCK_KEY 8'hD8
`endif

// >>> hw/rsc_pkg.sv
// types of the system reset controller
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_HOLD,
        RSC_FUSE,
        RSC_INIT,
        RSC_RUN
    } rsc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsc_bus_t;

    typedef struct packed {
        logic debug;
        logic watchdog;
        logic brownout;
        logic power_on;
    } rsc_req_t;

    typedef struct packed {
        logic general;
        logic brownout_cfg;
        logic debug_logic;
        logic fuse_reload;
    } rsc_domain_t;
endpackage

// >>> hw/rsc_sync.sv
// two flop synchroniser with an asynchronous preset
`timescale 1ns/1ps
module rsc_sync (
    input wire logic clk,
    input wire logic preset,
    input wire logic d,
    output logic q
);
    logic meta;
    // preset asserts at once, release leaves only through both flops
    always_ff @(posedge clk or posedge preset) begin
        if (preset) begin
            meta <= 1'b1;
            q <= 1'b1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> hw/rsc_ctrl.sv
// system reset controller: sources, sequencer, cause flags, software reset
`timescale 1ns/1ps
`include "rsc_params.svh"

module rsc_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire rsc_pkg::rsc_bus_t bus,
    output logic [7:0] rdata,
    input wire rsc_pkg::rsc_req_t req,
    input wire logic reset_pin_n,
    input wire logic reset_pin_fuse_config,
    input wire logic [2:0] startup_time_fuse,
    input wire logic boot_scan_select_fuse,
    input wire logic cpu_instr_done,
    output logic sys_reset,
    output rsc_pkg::rsc_domain_t domain_reset,
    output logic timer_pin_override,
    output logic fuse_load,
    output logic code_memory_scanner
);
    import rsc_pkg::*;

    localparam logic [15:0] INIT_BASE = 16'(`RSC_INIT_BASE);
    localparam logic [15:0] SUT_STEP = 16'(`RSC_SUT_STEP);
    localparam logic [15:0] SCAN_CYCLES = 16'(`RSC_SCAN_CYCLES);
    localparam logic [15:0] FUSE_LOAD = 16'(`RSC_FUSE_LOAD);
    localparam logic [2:0] CCP_WINDOW = 3'(`RSC_CCP_WINDOW);

    rsc_state_t state;
    logic [15:0] count;
    logic pin_level;
    logic por_sync;
    logic bod_sync;
    logic wdog_sync;
    logic debug_sync;
    logic soft_pending;
    logic [2:0] unlock_left;
    logic [7:0] cause_flags;
    logic por_since_boot;
    logic [5:0] latched_cause;
    logic any_source;
    logic por_now;
    logic unlocked;
    logic cause_wr;
    logic swrst_wr;
    logic key_wr;
    logic [15:0] next_init_len;

    // pin passes two flops before use; the preset is only the constant 0
    rsc_sync pin_sync (
        .clk(clk),
        .preset(1'b0),
        .d(reset_pin_n),
        .q(pin_level)
    );

    // detector requests are from other domains too: two flops each
    logic [1:0] por_ff, bod_ff, wdog_ff, debug_ff;
    always_ff @(posedge clk) begin
        por_ff <= {por_ff[0], req.power_on};
        bod_ff <= {bod_ff[0], req.brownout};
        wdog_ff <= {wdog_ff[0], req.watchdog};
        debug_ff <= {debug_ff[0], req.debug};
    end
    assign por_sync = por_ff[1];
    assign bod_sync = bod_ff[1];
    assign wdog_sync = wdog_ff[1];
    assign debug_sync = debug_ff[1];

    // power-on is never gated by clk_en or mode so it always reaches the sequencer
    assign por_now = por_sync | sys_rst;
    assign any_source = por_now | bod_sync | wdog_sync | debug_sync | soft_pending
        | (reset_pin_fuse_config & ~pin_level);

    assign cause_wr = bus.wr && bus.addr == `RSC_OFF_CAUSE;
    assign swrst_wr = bus.wr && bus.addr == `RSC_OFF_SWRST;
    assign key_wr = bus.wr && bus.wdata == `RSC_KEY_IO_REGISTER_UNLOCK_KEY && bus.addr != `RSC_OFF_SWRST;
    assign unlocked = unlock_left != 3'h0;

    // startup fuse and optional scan stretch the init phase
    assign next_init_len = 16'(INIT_BASE + SUT_STEP * 16'(startup_time_fuse)
        + (boot_scan_select_fuse ? SCAN_CYCLES : 16'h0000));

    // protection window counts instructions after the key
    always_ff @(posedge clk) begin
        if (por_now || state != RSC_RUN) begin
            unlock_left <= 3'h0;
        end else if (clk_en) begin
            if (key_wr) begin
                unlock_left <= CCP_WINDOW;
            end else if (swrst_wr) begin
                unlock_left <= 3'h0;
            end else if (cpu_instr_done && unlocked) begin
                unlock_left <= 3'(unlock_left - 3'h1);
            end
        end
    end

    // software trigger is held in soft_pending only until run is left; it always reads zero
    always_ff @(posedge clk) begin
        if (por_now) begin
            soft_pending <= 1'b0;
        end else if (state != RSC_RUN) begin
            soft_pending <= 1'b0;
        end else if (clk_en && swrst_wr && unlocked && bus.wdata[`RSC_BIT_TRIGGER]) begin
            soft_pending <= 1'b1;
        end
    end

    // sequencer: hold while any source, reload fuses, then initialise
    always_ff @(posedge clk) begin
        if (por_now) begin
            state <= RSC_HOLD;
            count <= 16'h0000;
        end else if (any_source) begin
            state <= RSC_HOLD;
            count <= 16'h0000;
        end else begin
            unique case (state)
                RSC_HOLD: begin
                    state <= RSC_FUSE;
                    count <= FUSE_LOAD;
                end
                RSC_FUSE: begin
                    if (count == 16'h0001) begin
                        state <= RSC_INIT;
                        count <= next_init_len;
                    end else begin
                        count <= 16'(count - 16'h0001);
                    end
                end
                RSC_INIT: begin
                    if (count <= 16'h0001) begin
                        state <= RSC_RUN;
                    end else begin
                        count <= 16'(count - 16'h0001);
                    end
                end
                RSC_RUN: begin
                    count <= 16'h0000;
                end
            endcase
        end
    end

    // causes seen during the hold are latched then kept until run;
    // the edge that leaves run must latch too, or a one-cycle soft request is lost
    always_ff @(posedge clk) begin
        if (por_now || (state == RSC_RUN && !any_source)) begin
            latched_cause <= 6'h00;
        end else begin
            latched_cause[`RSC_BIT_BOD] <= latched_cause[`RSC_BIT_BOD] | bod_sync;
            latched_cause[`RSC_BIT_PIN] <= latched_cause[`RSC_BIT_PIN]
                | (reset_pin_fuse_config & ~pin_level);
            latched_cause[`RSC_BIT_WDOG] <= latched_cause[`RSC_BIT_WDOG] | wdog_sync;
            latched_cause[`RSC_BIT_SOFT] <= latched_cause[`RSC_BIT_SOFT] | soft_pending;
            latched_cause[`RSC_BIT_DEBUG] <= latched_cause[`RSC_BIT_DEBUG] | debug_sync;
            latched_cause[`RSC_BIT_POR] <= 1'b0;
        end
    end

    // after power-on, other flags stay blocked until the first boot ends
    always_ff @(posedge clk) begin
        if (por_now) begin
            por_since_boot <= 1'b1;
        end else if (state == RSC_RUN) begin
            por_since_boot <= 1'b0;
        end
    end

    // flags: set in the last init cycle, write one clears; a set wins over a clear
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_flag
            always_ff @(posedge clk) begin
                if (por_now) begin
                    cause_flags[gi] <= (gi == `RSC_BIT_POR);
                end else if (state == RSC_INIT && count == 16'h0001 && !por_since_boot
                        && latched_cause[gi]) begin
                    cause_flags[gi] <= 1'b1;
                end else if (clk_en && cause_wr && bus.wdata[gi]) begin
                    cause_flags[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        cause_flags[7:6] <= 2'b00;
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (clk_en && bus.rd && bus.addr == `RSC_OFF_CAUSE) begin
            rdata <= cause_flags & `RSC_CAUSE_MASK;
        end else begin
            rdata <= `RSC_SWRST_RESET;
        end
    end

    // domain resets follow the kind of reset in progress
    always_ff @(posedge clk) begin
        if (por_now) begin
            sys_reset <= 1'b1;
            domain_reset <= '{general: 1'b1, brownout_cfg: 1'b1, debug_logic: 1'b1,
                fuse_reload: 1'b1};
            timer_pin_override <= 1'b0;
        end else begin
            sys_reset <= state != RSC_RUN || any_source;
            domain_reset.general <= state != RSC_RUN || any_source;
            domain_reset.brownout_cfg <= 1'b0;
            domain_reset.debug_logic <= bod_sync;
            domain_reset.fuse_reload <= state != RSC_RUN || any_source;
            timer_pin_override <= !por_since_boot;
        end
    end

    // fuse load strobe and boot scan request
    always_ff @(posedge clk) begin
        if (por_now) begin
            fuse_load <= 1'b0;
            code_memory_scanner <= 1'b0;
        end else begin
            fuse_load <= state == RSC_FUSE && !any_source;
            code_memory_scanner <= state == RSC_INIT && boot_scan_select_fuse;
        end
    end
endmodule

// >>> verif/rsc_srcs.sv
// model of the reset sources around the controller
`timescale 1ns/1ps
module rsc_srcs (
    input wire logic [4:0] raise,
    output rsc_pkg::rsc_req_t req,
    output logic reset_pin_n
);
    import rsc_pkg::*;
    // debug request only when the bench plays the debugger
    assign req = rsc_req_t'(raise[3:0]);
    // pin rests high through its pull-up, low requests
    assign reset_pin_n = ~raise[4];
endmodule

// >>> verif/rsc_ctrl_chk.sv
// assertions of the system reset controller
`timescale 1ns/1ps
module rsc_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire rsc_pkg::rsc_bus_t bus,
    input wire logic [7:0] rdata,
    input wire rsc_pkg::rsc_req_t req,
    input wire logic reset_pin_n,
    input wire logic reset_pin_fuse_config,
    input wire logic [2:0] startup_time_fuse,
    input wire logic boot_scan_select_fuse,
    input wire logic sys_reset,
    input wire logic timer_pin_override,
    input wire logic fuse_load
);
    import rsc_pkg::*;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_key;
        clk_en && bus.wr && bus.addr != 8'h01 && bus.wdata == 8'hD8;
    endsequence
    sequence s_trig;
        clk_en && bus.wr && bus.addr == 8'h01 && bus.wdata[0];
    endsequence
    sequence s_clr;
        clk_en && bus.wr && bus.addr == 8'h00 && bus.wdata == 8'h3F && !sys_reset;
    endsequence
    sequence s_rdc;
        clk_en && bus.rd && bus.addr == 8'h00 && !sys_reset;
    endsequence
    property p_trig;
        s_key ##1 s_trig |-> ##2 sys_reset;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger ignored");
    property p_clr;
        s_clr ##1 s_rdc |=> rdata == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("flags kept");
    // two sync flops plus the reset register
    property p_por;
        req.power_on |-> ##[0:4] sys_reset;
    endproperty
    a_por: assert property (p_por) else $error("power-on ignored");
    property p_wdog;
        req.watchdog |-> ##[0:4] sys_reset;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog ignored");
    property p_pin;
        (reset_pin_fuse_config && !reset_pin_n) [*3] |-> ##[0:2] sys_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("pin ignored");
    property p_rd0;
        $past(clk_en && bus.rd && bus.addr == 8'h01) |-> rdata == 8'h00;
    endproperty
    a_rd0: assert property (p_rd0) else $error("trigger reads one");
    // window is loose: only the shortest fuse setting is timed
    property p_init;
        $fell(fuse_load) && startup_time_fuse == 3'h0 && !boot_scan_select_fuse
            |-> sys_reset [*8] ##[8:20] !sys_reset;
    endproperty
    a_init: assert property (p_init) else $error("init length");
    property p_tpo;
        !req.power_on && timer_pin_override |=> timer_pin_override;
    endproperty
    a_tpo: assert property (p_tpo) else $error("override lost");
endmodule
bind rsc_ctrl rsc_chk rsc_chk_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bus(bus),
    .rdata(rdata),
    .req(req),
    .reset_pin_n(reset_pin_n),
    .reset_pin_fuse_config(reset_pin_fuse_config),
    .startup_time_fuse(startup_time_fuse),
    .boot_scan_select_fuse(boot_scan_select_fuse),
    .sys_reset(sys_reset),
    .timer_pin_override(timer_pin_override),
    .fuse_load(fuse_load)
);

// >>> verif/rsc_ctrl_bench.sv
// self-checking bench of the system reset controller
`timescale 1ns/1ps
module rsc_ctrl_bench;
    import rsc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pin_en = 1'b1;
    logic instr = 1'b0;
    logic [4:0] raise = 5'h00;
    rsc_bus_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] d;
    rsc_req_t req;
    logic reset_pin_n;
    logic sys_reset;
    int n_mismatch = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    rsc_srcs rsc_srcs_inst (.raise(raise), .req(req), .reset_pin_n(reset_pin_n));
    rsc_ctrl rsc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus),
        .rdata(rdata), .req(req), .reset_pin_n(reset_pin_n),
        .reset_pin_fuse_config(pin_en), .startup_time_fuse(3'h0),
        .boot_scan_select_fuse(1'b0), .cpu_instr_done(instr), .sys_reset(sys_reset),
        .domain_reset(), .timer_pin_override(), .fuse_load(), .code_memory_scanner());
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobe stays up so back-to-back writes never assign twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
    endtask
    task automatic idle;
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rdata;
        @(posedge clk);
    endtask
    task automatic wait_rst(input logic lvl);
        for (int i = 0; i < 600 && sys_reset !== lvl; i++) begin
            @(posedge clk);
        end
        cmp("sys_reset", {7'h00, lvl}, {7'h00, sys_reset});
    endtask
    task automatic t_boot;
        wait_rst(1'b0);
        rd(8'h00);
        cmp("cause", 8'h01, d);
        rd(8'h01);
        cmp("swreg", 8'h00, d);
        wr(8'h00, 8'h00);
        rd(8'h00);
        cmp("cause", 8'h01, d);
        wr(8'h00, 8'h01);
        rd(8'h00);
        cmp("cause", 8'h00, d);
    endtask
    task automatic t_lock;
        wr(8'h01, 8'h01);
        idle;
        repeat (3) @(posedge clk);
        cmp("unkeyed", 8'h00, {7'h00, sys_reset});
        wr(8'h02, 8'hD8);
        idle;
        instr <= 1'b1;
        repeat (5) @(posedge clk);
        instr <= 1'b0;
        wr(8'h01, 8'h01);
        idle;
        repeat (3) @(posedge clk);
        cmp("late", 8'h00, {7'h00, sys_reset});
    endtask
    task automatic t_soft;
        wr(8'h02, 8'hD8);
        wr(8'h01, 8'h01);
        idle;
        #1;
        cmp("soft", 8'h01, {7'h00, sys_reset});
        wait_rst(1'b0);
        rd(8'h00);
        cmp("cause", 8'h10, d);
        wr(8'h00, 8'h3F);
        rd(8'h00);
        cmp("cleared", 8'h00, d);
    endtask
    task automatic t_src;
        int fl[4] = '{1, 3, 5, 2};
        for (int k = 0; k < 4; k++) begin
            raise <= 5'h01 << (k + 1);
            repeat (20) @(posedge clk);
            cmp("held", 8'h01, {7'h00, sys_reset});
            raise <= 5'h00;
            wait_rst(1'b0);
            rd(8'h00);
            cmp("cause", 8'h01 << fl[k], d);
            wr(8'h00, 8'h3F);
            idle;
        end
        pin_en <= 1'b0;
        raise <= 5'h10;
        repeat (20) @(posedge clk);
        cmp("pin off", 8'h00, {7'h00, sys_reset});
        raise <= 5'h00;
    endtask
    task automatic t_por;
        raise <= 5'h05;
        repeat (20) @(posedge clk);
        cmp("por", 8'h01, {7'h00, sys_reset});
        raise <= 5'h00;
        wait_rst(1'b0);
        rd(8'h00);
        cmp("cause", 8'h01, d);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_boot;
        t_lock;
        t_soft;
        t_src;
        t_por;
        complete_run;
    end
    // the run needs well under 1000 cycles
    initial begin
        #100000;
        n_mismatch++;
        complete_run;
    end
endmodule
